// ==== shared/hpas_defs.svh ====
`ifndef HPAS_DEFS_SVH
`define HPAS_DEFS_SVH

// Forced addresses used on default-programmed parts while enable and alarm are both held low
`define HPAS_FORCED_I2C_ADDR 7'h0A
`define HPAS_FORCED_PMBUS_ADDR 7'h0D

// Unlock attempts allowed before the lock-up state
`define HPAS_FAIL_LIMIT 3'h4

// Register selectors on the register request port
`define HPAS_SEL_ATTEMPT_HI 3'h0
`define HPAS_SEL_ATTEMPT_LO 3'h1
`define HPAS_SEL_KEY_HI 3'h2
`define HPAS_SEL_KEY_LO 3'h3
`define HPAS_SEL_OTHER 3'h4

// Value that can never serve as a key
`define HPAS_KEY_INVALID 16'h0000

`endif

// ==== shared/hpas_pkg.sv ====
package hpas_pkg;

  // Read protection levels
  typedef enum logic [1:0] {
    HPAS_RD_NONE,
    HPAS_RD_CFG,
    HPAS_RD_ALL_BUT_TELE,
    HPAS_RD_ALL
  } hpas_rd_level_t;

  // Write protection levels
  typedef enum logic [1:0] {
    HPAS_WR_NONE,
    HPAS_WR_CFG,
    HPAS_WR_ALL
  } hpas_wr_level_t;

  // Unlock methods
  typedef enum logic [1:0] {
    HPAS_UNL_KEY,
    HPAS_UNL_PIN,
    HPAS_UNL_PIN_KEY,
    HPAS_UNL_NEVER
  } hpas_unlock_t;

  // Class of the register a bus access aims at
  typedef enum logic [1:0] {
    HPAS_CLS_CFG,
    HPAS_CLS_TELE,
    HPAS_CLS_OTHER
  } hpas_class_t;

  // Settings held in the nonvolatile store
  typedef struct packed {
    logic default_prog;
    logic offset_en;
    logic [6:0] i2c_base;
    logic [6:0] pmbus_base;
    hpas_rd_level_t rd_level;
    hpas_wr_level_t wr_level;
    hpas_unlock_t rd_unlock;
    hpas_unlock_t wr_unlock;
    logic [15:0] key;
  } hpas_nvm_t;

  // One register access from the two-wire engine
  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] sel;
    hpas_class_t cls;
    logic [7:0] data;
  } hpas_req_t;

endpackage

// ==== hdl/hpas_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
module hpas_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// ==== hdl/hpas_top.sv ====
`include "hpas_defs.svh"

// Behaviour
// R1 - Answer I2C and PMBus addresses concurrently
// R2 - Independent configurable 7-bit I2C address
// R3 - Offset-enable bit gates strap offset
// R4 - Add strap code 0..15 to both
// R5 - Lock address once established
// R6 - Enable and alarm low force fixed addresses; the code forces them only when default_prog is also set
// R7 - Four read protection levels
// R8 - Three separate write protection levels
// R9 - Unlock by key, pin, both, never
// R10 - Sixteen-bit stored key, zero never valid
// R11 - Attempt register must match stored key
// R12 - Four wrong attempts lock up unlocking
// R13 - Lock pin high unlocks, low relocks
// R14 - Sample strap at enable, then lock pin
// R15 - High byte first; low byte compares
// R16 - Protected writes dropped, transaction completes
// R17 - Reset clears fail count and unlock
module hpas_top
  import hpas_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic ENABLE,
  input wire logic THERMAL_ALARM_PIN,
  input wire logic STRAP_LOCK_PIN,
  input wire logic [3:0] STRAP_CODE,
  input hpas_nvm_t NVM_CFG,
  input wire logic [6:0] BUS_ADDR,
  output logic I2C_HIT,
  output logic PMBUS_HIT,
  output logic [6:0] I2C_ADDR,
  output logic [6:0] PMBUS_ADDR,
  output logic ADDR_LOCKED,
  input hpas_req_t REG_REQ,
  output logic REG_ACK,
  output logic WRITE_ALLOW,
  output logic READ_ALLOW,
  output logic [7:0] RD_DATA,
  output logic NVM_KEY_WR,
  output logic [15:0] NVM_KEY_DATA,
  output logic KEY_UNLOCKED,
  output logic LOCKED_UP,
  output logic RD_UNLOCKED,
  output logic WR_UNLOCKED
);

  logic en_s;
  logic alarm_s;
  logic lock_pin_s;
  logic [3:0] strap_s;

  // Pin synchronisers
  hpas_sync #(.W(3)) u_sync_lvl (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .din({ENABLE, THERMAL_ALARM_PIN, STRAP_LOCK_PIN}),
    .dout({en_s, alarm_s, lock_pin_s})
  );

  hpas_sync #(.W(4)) u_sync_strap (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .din(STRAP_CODE),
    .dout(strap_s)
  );

  // Address state
  logic en_prev_q, en_prev_d;
  logic locked_q, locked_d;
  logic [6:0] i2c_q, i2c_d;
  logic [6:0] pmb_q, pmb_d;
  logic [3:0] offset_q, offset_d;
  logic forced;

  // Latch strap and fix addresses on first enable
  always_comb
  begin
    en_prev_d = en_s;
    locked_d = locked_q;
    i2c_d = i2c_q;
    pmb_d = pmb_q;
    offset_d = offset_q;
    if (!locked_q)
    begin
      i2c_d = NVM_CFG.i2c_base; // R2
      pmb_d = NVM_CFG.pmbus_base;
      if (en_s && !en_prev_q)
      begin
        offset_d = NVM_CFG.offset_en ? strap_s : 4'h0; // R3 R14
        i2c_d = NVM_CFG.i2c_base + {3'h0, offset_d}; // R4
        pmb_d = NVM_CFG.pmbus_base + {3'h0, offset_d}; // R4
        locked_d = 1'b1; // R5
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      en_prev_q <= 1'b0;
      locked_q <= 1'b0;
      i2c_q <= 7'h00;
      pmb_q <= 7'h00;
      offset_q <= 4'h0;
    end
    else
    begin
      en_prev_q <= en_prev_d;
      locked_q <= locked_d;
      i2c_q <= i2c_d;
      pmb_q <= pmb_d;
      offset_q <= offset_d;
    end
  end

  // Fixed addresses for default-programmed parts
  assign forced = NVM_CFG.default_prog && !en_s && !alarm_s; // R6
  assign I2C_ADDR = forced ? `HPAS_FORCED_I2C_ADDR : i2c_q; // R6
  assign PMBUS_ADDR = forced ? `HPAS_FORCED_PMBUS_ADDR : pmb_q; // R6
  assign ADDR_LOCKED = locked_q;

  // Both decoders run side by side
  assign I2C_HIT = (BUS_ADDR == I2C_ADDR); // R1
  assign PMBUS_HIT = (BUS_ADDR == PMBUS_ADDR); // R1

  // Unlock state
  logic [7:0] att_hi_q, att_hi_d;
  logic [7:0] att_lo_q, att_lo_d;
  logic [15:0] key_q, key_d;
  logic key_loaded_q, key_loaded_d;
  logic key_ok_q, key_ok_d;
  logic [2:0] fails_q, fails_d;
  logic [7:0] rd_q, rd_d;
  logic nvm_wr_q, nvm_wr_d;
  logic lockup;
  logic rd_unl;
  logic wr_unl;
  logic rd_prot;
  logic wr_prot;
  logic wr_ok;
  logic rd_ok;
  logic [15:0] cand;

  // Release condition for one unlock method
  function automatic logic method_open(hpas_unlock_t m, logic key_ok, logic pin);
    logic r;
    r = 1'b0;
    unique case (m)
      HPAS_UNL_KEY: r = key_ok;
      HPAS_UNL_PIN: r = pin; // R13
      HPAS_UNL_PIN_KEY: r = key_ok && pin;
      HPAS_UNL_NEVER: r = 1'b0;
    endcase
    return r; // R9
  endfunction

  assign lockup = (fails_q >= `HPAS_FAIL_LIMIT); // R12
  assign rd_unl = method_open(NVM_CFG.rd_unlock, key_ok_q, lock_pin_s); // R9
  assign wr_unl = method_open(NVM_CFG.wr_unlock, key_ok_q, lock_pin_s); // R9

  // Read protection by level and register class
  always_comb
  begin
    rd_prot = 1'b0;
    unique case (NVM_CFG.rd_level)
      HPAS_RD_NONE: rd_prot = 1'b0;
      HPAS_RD_CFG: rd_prot = (REG_REQ.cls == HPAS_CLS_CFG);
      HPAS_RD_ALL_BUT_TELE: rd_prot = (REG_REQ.cls != HPAS_CLS_TELE);
      HPAS_RD_ALL: rd_prot = 1'b1;
    endcase // R7
  end

  // Write protection by level and register class
  always_comb
  begin
    wr_prot = 1'b0;
    unique case (NVM_CFG.wr_level)
      HPAS_WR_NONE: wr_prot = 1'b0;
      HPAS_WR_CFG: wr_prot = (REG_REQ.cls == HPAS_CLS_CFG);
      HPAS_WR_ALL: wr_prot = 1'b1;
      default: wr_prot = 1'b1;
    endcase // R8
  end

  // Attempt register stays reachable so a locked part can be opened
  assign wr_ok = (REG_REQ.sel == `HPAS_SEL_ATTEMPT_HI) || (REG_REQ.sel == `HPAS_SEL_ATTEMPT_LO)
    || !wr_prot || wr_unl;
  assign rd_ok = (REG_REQ.sel == `HPAS_SEL_ATTEMPT_HI) || (REG_REQ.sel == `HPAS_SEL_ATTEMPT_LO)
    || !rd_prot || rd_unl;
  assign cand = {att_hi_q, REG_REQ.data};

  // Attempt, key and read-back next state
  always_comb
  begin
    att_hi_d = att_hi_q;
    att_lo_d = att_lo_q;
    key_d = key_q;
    key_loaded_d = key_loaded_q;
    key_ok_d = key_ok_q;
    fails_d = fails_q;
    rd_d = rd_q;
    nvm_wr_d = 1'b0;
    if (!key_loaded_q)
    begin
      key_d = NVM_CFG.key;
      key_loaded_d = 1'b1;
    end
    if (REG_REQ.valid && REG_REQ.write && wr_ok) // R16
    begin
      unique case (REG_REQ.sel)
        `HPAS_SEL_ATTEMPT_HI: att_hi_d = REG_REQ.data; // R15
        `HPAS_SEL_ATTEMPT_LO:
        begin
          att_lo_d = REG_REQ.data;
          if (!lockup) // R12
          begin
            if (cand == key_q && key_q != `HPAS_KEY_INVALID) // R10 R11 R15
            begin
              key_ok_d = 1'b1;
            end
            else
            begin
              key_ok_d = 1'b0;
              fails_d = fails_q + 3'h1; // R12
            end
          end
        end
        `HPAS_SEL_KEY_HI:
        begin
          key_d = {REG_REQ.data, key_q[7:0]};
          key_ok_d = 1'b0;
          nvm_wr_d = 1'b1;
        end
        `HPAS_SEL_KEY_LO:
        begin
          key_d = {key_q[15:8], REG_REQ.data};
          key_ok_d = 1'b0;
          nvm_wr_d = 1'b1;
        end
        default: nvm_wr_d = 1'b0;
      endcase
    end
    if (REG_REQ.valid && !REG_REQ.write)
    begin
      if (!rd_ok)
      begin
        rd_d = 8'h00;
      end
      else
      begin
        unique case (REG_REQ.sel)
          `HPAS_SEL_ATTEMPT_HI: rd_d = att_hi_q;
          `HPAS_SEL_ATTEMPT_LO: rd_d = att_lo_q;
          `HPAS_SEL_KEY_HI: rd_d = key_q[15:8];
          `HPAS_SEL_KEY_LO: rd_d = key_q[7:0];
          default: rd_d = 8'h00;
        endcase
      end
    end
  end

  // Reset returns to the locked defaults
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      att_hi_q <= 8'h00;
      att_lo_q <= 8'h00;
      key_q <= 16'h0000;
      key_loaded_q <= 1'b0;
      key_ok_q <= 1'b0; // R17
      fails_q <= 3'h0; // R17
      rd_q <= 8'h00;
      nvm_wr_q <= 1'b0;
    end
    else
    begin
      att_hi_q <= att_hi_d;
      att_lo_q <= att_lo_d;
      key_q <= key_d;
      key_loaded_q <= key_loaded_d;
      key_ok_q <= key_ok_d;
      fails_q <= fails_d;
      rd_q <= rd_d;
      nvm_wr_q <= nvm_wr_d;
    end
  end

  // Handshake and status outputs
  assign REG_ACK = REG_REQ.valid; // R16
  assign WRITE_ALLOW = REG_REQ.valid && REG_REQ.write && wr_ok;
  assign READ_ALLOW = REG_REQ.valid && !REG_REQ.write && rd_ok;
  assign RD_DATA = rd_q;
  assign NVM_KEY_WR = nvm_wr_q;
  assign NVM_KEY_DATA = key_q;
  assign KEY_UNLOCKED = key_ok_q;
  assign LOCKED_UP = lockup;
  assign RD_UNLOCKED = rd_unl;
  assign WR_UNLOCKED = wr_unl;

endmodule

// ==== verif/hpas_properties.sv ====
`include "hpas_defs.svh"
// Port checks of the address and access front end
module hpas_checker
  import hpas_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [6:0] BUS_ADDR,
  input wire logic I2C_HIT,
  input wire logic PMBUS_HIT,
  input wire logic [6:0] I2C_ADDR,
  input wire logic [6:0] PMBUS_ADDR,
  input wire logic ADDR_LOCKED,
  input hpas_req_t REG_REQ,
  input wire logic REG_ACK,
  input wire logic WRITE_ALLOW,
  input wire logic READ_ALLOW,
  input wire logic [7:0] RD_DATA,
  input wire logic NVM_KEY_WR,
  input wire logic [15:0] NVM_KEY_DATA,
  input wire logic KEY_UNLOCKED,
  input wire logic LOCKED_UP
);
  timeunit 1ns;
  timeprecision 1ps;
  logic kdrop;
  logic kwr;
  // Accepted key byte write
  assign kwr = REG_REQ.valid && REG_REQ.write && WRITE_ALLOW
    && (REG_REQ.sel == `HPAS_SEL_KEY_HI || REG_REQ.sel == `HPAS_SEL_KEY_LO);
  // Refused key high-byte write
  assign kdrop = REG_REQ.valid && REG_REQ.write && REG_REQ.sel == `HPAS_SEL_KEY_HI && !WRITE_ALLOW;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  AST_ACK: assert property (REG_ACK == REG_REQ.valid) else $error("ack wrong");
  AST_I2C_HIT: assert property (I2C_HIT == (BUS_ADDR == I2C_ADDR)) else $error("i2c hit");
  AST_PMB_HIT: assert property (PMBUS_HIT == (BUS_ADDR == PMBUS_ADDR)) else $error("pm hit");
  AST_ADDR_HOLD: assert property (ADDR_LOCKED |=> ADDR_LOCKED) else $error("addr lock");
  AST_LOCK_HOLD: assert property (LOCKED_UP |=> LOCKED_UP) else $error("lockup");
  AST_ZERO_KEY: assert property (NVM_KEY_DATA == `HPAS_KEY_INVALID |-> !KEY_UNLOCKED)
    else $error("zero key");
  AST_WR_DROP: assert property (kdrop |=> !NVM_KEY_WR && $stable(NVM_KEY_DATA))
    else $error("write kept");
  AST_RD_ZERO: assert property (REG_REQ.valid && !REG_REQ.write && !READ_ALLOW |=>
    RD_DATA == 8'h00)
    else $error("rd data");
  AST_KEY_WR: assert property (kwr |=> NVM_KEY_WR && !KEY_UNLOCKED)
    else $error("key write lost");
  cover property (kdrop);
  cover property ($rose(KEY_UNLOCKED));
  cover property ($rose(LOCKED_UP));
  cover property ($rose(ADDR_LOCKED));
endmodule
bind hpas_top hpas_checker hpas_checker_i (.SYS_CLK, .RSTN, .BUS_ADDR, .I2C_HIT, .PMBUS_HIT,
  .I2C_ADDR, .PMBUS_ADDR, .ADDR_LOCKED, .REG_REQ, .REG_ACK, .WRITE_ALLOW, .READ_ALLOW,
  .RD_DATA, .NVM_KEY_WR, .NVM_KEY_DATA, .KEY_UNLOCKED, .LOCKED_UP);

// ==== verif/hpas_master.sv ====
`include "hpas_defs.svh"
// Bus master model
module hpas_master
  import hpas_pkg::*;
(
  input wire logic clk,
  output hpas_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial
  begin
    req = '0;
  end
  // Access to a register of a given class
  task automatic acc_c(input logic w, input logic [2:0] s, input hpas_class_t c,
    input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, w, s, c, d};
  endtask
  // Access held over its taking edge
  task automatic acc(input logic w, input logic [2:0] s, input logic [7:0] d);
    acc_c(w, s, HPAS_CLS_CFG, d);
  endtask
  // Release with flipped leftovers
  task automatic idle();
    @(negedge clk);
    req.valid = 1'b0;
    req.data = ~req.data;
    @(negedge clk);
  endtask
  // Attempt, high byte first
  task automatic try_key(input logic [15:0] k);
    acc(1'b1, `HPAS_SEL_ATTEMPT_HI, k[15:8]);
    acc(1'b1, `HPAS_SEL_ATTEMPT_LO, k[7:0]);
    idle();
  endtask
endmodule

// ==== verif/tb_hpas_top.sv ====
`include "hpas_defs.svh"
module tb_hpas_top
  import hpas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, alarm = 1'b0, pin = 1'b0;
  logic [3:0] sc = 4'h0;
  logic [6:0] ba = 7'h00, ia, pa, pe;
  logic ih, ph, ku, lu, ru, wu;
  logic [7:0] rd;
  logic [15:0] key;
  logic [31:0] lf = 32'h0000E8A5;
  hpas_nvm_t cfg = '0;
  hpas_req_t req;
  int n_fail = 0, n_checks = 0;
  hpas_top hpas_top_i (.SYS_CLK(clk), .RSTN(rst_n), .ENABLE(en), .THERMAL_ALARM_PIN(alarm),
    .STRAP_LOCK_PIN(pin), .STRAP_CODE(sc), .NVM_CFG(cfg), .BUS_ADDR(ba), .I2C_HIT(ih),
    .PMBUS_HIT(ph), .I2C_ADDR(ia), .PMBUS_ADDR(pa), .ADDR_LOCKED(), .REG_REQ(req), .REG_ACK(),
    .WRITE_ALLOW(), .READ_ALLOW(), .RD_DATA(rd), .NVM_KEY_WR(), .NVM_KEY_DATA(key),
    .KEY_UNLOCKED(ku), .LOCKED_UP(lu), .RD_UNLOCKED(ru), .WR_UNLOCKED(wu));
  hpas_master hpas_master_i (.clk(clk), .req(req));
  // Clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Next random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Base plus optional strap offset
  function automatic logic [6:0] exp_a(input logic [6:0] b, input logic [3:0] c, input logic o);
    return o ? b + {3'h0, c} : b;
  endfunction
  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] x);
    n_checks++;
    if (s !== x)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  // Verdict
  task automatic report_and_stop();
    $display("%0d checks %0d fails", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Six-cycle reset
  task automatic rst();
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  // Hang guard
  initial
  begin
    repeat (4000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // Scenarios
  initial
  begin
    cfg.default_prog = 1'b1;
    rst();
    chk("ku", ku, 1'h0);
    chk("fi", ia, 7'h0A);
    chk("fp", pa, 7'h0D);
    alarm = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr(lf);
      cfg.i2c_base = lf[6:0];
      cfg.pmbus_base = lf[13:7];
      cfg.offset_en = i[0];
      sc = i[1] ? 4'hF : lf[17:14];
      en = 1'b0;
      rst();
      en = 1'b1;
      repeat (4) @(negedge clk);
      ba = exp_a(cfg.i2c_base, sc, i[0]);
      pe = exp_a(cfg.pmbus_base, sc, i[0]);
      chk("pa", pa, pe);
      chk("ia", ia, ba);
      sc = ~sc;
      cfg.i2c_base = ~ba;
      cfg.pmbus_base = ~pe;
      repeat (4) @(negedge clk);
      chk("ih", ih, 1'h1);
      ba = pe;
      @(negedge clk);
      chk("ph", ph, 1'h1);
    end
    $display("addr done");
    cfg.rd_level = HPAS_RD_ALL;
    cfg.wr_level = HPAS_WR_ALL;
    cfg.key = lf[15:0] | 16'h0001;
    rst();
    hpas_master_i.acc(1'b1, `HPAS_SEL_ATTEMPT_HI, 8'hA5);
    hpas_master_i.acc(1'b0, `HPAS_SEL_ATTEMPT_HI, 8'h00);
    hpas_master_i.idle();
    chk("ra", rd, 8'hA5);
    hpas_master_i.acc(1'b0, `HPAS_SEL_OTHER, lf[23:16]);
    hpas_master_i.acc(1'b1, `HPAS_SEL_KEY_HI, ~cfg.key[15:8]);
    hpas_master_i.idle();
    chk("rd", rd, 8'h00);
    chk("kp", key, cfg.key);
    hpas_master_i.try_key(cfg.key);
    chk("ku", ku, 1'h1);
    chk("wu", wu, 1'h1);
    chk("ru", ru, 1'h1);
    hpas_master_i.acc(1'b0, `HPAS_SEL_KEY_LO, 8'h00);
    hpas_master_i.idle();
    chk("rk", rd, cfg.key[7:0]);
    hpas_master_i.acc(1'b1, `HPAS_SEL_KEY_HI, lf[31:24]);
    hpas_master_i.idle();
    chk("kn", key, {lf[31:24], cfg.key[7:0]});
    chk("kc", ku, 1'h0);
    $display("key done");
    rst();
    for (int j = 0; j < 4; j++)
    begin
      lf = lfsr(lf);
      hpas_master_i.try_key(cfg.key ^ {lf[15:1], 1'b1});
      chk("lu", lu, j == 3);
    end
    hpas_master_i.try_key(cfg.key);
    chk("ku", ku, 1'h0);
    rst();
    chk("lu", lu, 1'h0);
    $display("lockup done");
    cfg.rd_level = HPAS_RD_CFG;
    cfg.wr_level = HPAS_WR_CFG;
    rst();
    hpas_master_i.acc_c(1'b1, `HPAS_SEL_KEY_LO, HPAS_CLS_TELE, 8'h5A);
    hpas_master_i.acc_c(1'b1, `HPAS_SEL_KEY_HI, HPAS_CLS_CFG, ~cfg.key[15:8]);
    hpas_master_i.acc_c(1'b0, `HPAS_SEL_KEY_LO, HPAS_CLS_TELE, 8'h00);
    hpas_master_i.idle();
    chk("kw", key, {cfg.key[15:8], 8'h5A});
    chk("rt", rd, 8'h5A);
    hpas_master_i.acc_c(1'b0, `HPAS_SEL_KEY_LO, HPAS_CLS_CFG, 8'h00);
    hpas_master_i.idle();
    chk("rc", rd, 8'h00);
    cfg.rd_level = HPAS_RD_ALL_BUT_TELE;
    hpas_master_i.acc_c(1'b0, `HPAS_SEL_KEY_LO, HPAS_CLS_TELE, 8'h00);
    hpas_master_i.idle();
    chk("rt", rd, 8'h5A);
    hpas_master_i.acc_c(1'b0, `HPAS_SEL_KEY_LO, HPAS_CLS_OTHER, 8'h00);
    hpas_master_i.idle();
    chk("ro", rd, 8'h00);
    $display("class done");
    cfg.wr_unlock = HPAS_UNL_PIN;
    cfg.rd_unlock = HPAS_UNL_NEVER;
    cfg.key = 16'h0000;
    rst();
    pin = 1'b1;
    hpas_master_i.try_key(16'h0000);
    chk("wu", wu, 1'h1);
    chk("ru", ru, 1'h0);
    chk("kz", ku, 1'h0);
    pin = 1'b0;
    repeat (3) @(negedge clk);
    chk("wl", wu, 1'h0);
    $display("pin done");
    report_and_stop();
  end
endmodule
